// [core/ata_sec_cmd.sv]
// Command handler for recalibrate and the security disable/erase commands.
// Assumes media control logic and the password store run on pclk.
//
// Functional notes
// - Recalibrate opcode 1xh seeks heads to cylinder zero before completing.
// - Failed seek sets track-zero-not-found error and status error bit.
// - Disable password first takes exactly one data-out sector from host.
// - Supplied password matching the selected stored one turns lock off.
// - Disable password never alters the stored master password.
// - Sector: word 0 bit 0 identifier, words 1-16 password, rest reserved.
// - Identifier zero compares user password, one compares master password.
// - Erase prepare has no data phase and only arms the next erase.
// - Erase unit without directly preceding prepare is aborted, nothing erased.
// - Erase unit takes one data-out sector with the same layout.
// - Erase password mismatch aborts the command and leaves data intact.
// - Erase zeroes LBA zero through native max, protected area included.
// - Erase does no read verify and leaves defect lists untouched.
// - Successful erase disables lock and keeps the master password.
// - With lock already disabled, erase skips compare and just erases.
// - Erase lasts up to an hour; host timeouts must allow for it.
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module ata_sec_cmd
	import ata_sec_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Password store
	input wire logic [pw_bits-1:0] user_password,
	input wire logic [pw_bits-1:0] master_password,
	input wire logic [lba_bits-1:0] native_max_lba,
	output logic lock_enabled,
	// Media control
	output media_req_type media_req,
	input wire media_rsp_type media_rsp
);

	cmd_state_type state;
	logic [7:0] error_flags;
	logic [7:0] drive_head_select;
	logic [7:0] command_opcode;
	logic status_err;
	logic seek_complete;
	logic erase_armed;
	logic [7:0] word_count;
	logic id_master;
	logic pw_mismatch;
	logic [7:0] drive_status;
	logic bus_access;
	logic wr_fire;
	logic cmd_write;
	logic data_write;
	logic sec_write;
	logic cmd_accept;
	logic [15:0] expect_word;
	logic [15:0] data_word;
	logic word_bad;
	logic sector_end;
	logic pw_ok;
	logic next_abort;
	logic next_done;
	logic [31:0] next_prdata;
	logic next_slverr;

	// Bus strobes: write lands on the edge that completes the access
	always_comb begin
		bus_access = psel && penable && !pready;
		wr_fire = psel && penable && pready && pwrite;
		cmd_write = wr_fire && (paddr == addr_command);
		data_write = wr_fire && (paddr == addr_data);
		sec_write = wr_fire && (paddr == addr_security);
		cmd_accept = cmd_write && (state == st_idle);
		data_word = pwdata[15:0];
	end

	always_comb begin
		drive_status = byte_zero;
		drive_status[st_busy_bit] = (state != st_idle) && (state != st_xfer);
		drive_status[st_ready_bit] = 1'b1;
		drive_status[st_seek_done_bit] = seek_complete;
		drive_status[st_drq_bit] = (state == st_xfer);
		drive_status[st_err_bit] = status_err;
	end

	// Password words picked by identifier, one word per data write
	always_comb begin
		expect_word = 16'h0000;
		word_bad = 1'b0;
		if (word_count >= pw_first_word && word_count <= pw_last_word) begin
			if (id_master) begin
				expect_word = master_password[(word_count - 8'h01) * 16 +: 16];
			end else begin
				expect_word = user_password[(word_count - 8'h01) * 16 +: 16];
			end
			word_bad = (data_word != expect_word);
		end
		sector_end = data_write && (word_count == sector_last_word);
		pw_ok = !pw_mismatch && !word_bad;
	end

	// Command sequencing and abort decision
	always_comb begin
		next_abort = 1'b0;
		next_done = 1'b0;
		if (state == st_xfer && sector_end) begin
			if (command_opcode == op_disable_pw) begin
				next_abort = !pw_ok;
				next_done = pw_ok;
			end else if (lock_enabled && !pw_ok) begin
				next_abort = 1'b1;
			end
		end
		if (cmd_accept && data_word[7:0] == op_erase_unit && !erase_armed) begin
			next_abort = 1'b1;
		end
		if (cmd_accept && data_word[7:0] == op_erase_prep) begin
			next_done = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= st_idle;
		end else begin
			unique case (state)
				st_idle: begin
					if (cmd_accept) begin
						if (pwdata[7:4] == op_recal_hi) begin
							state <= st_seek;
						end else if (pwdata[7:0] == op_disable_pw) begin
							state <= st_xfer;
						end else if (pwdata[7:0] == op_erase_unit &&
							erase_armed) begin
							state <= st_xfer;
						end
					end
				end
				st_seek: begin
					if (media_rsp.seek_done || media_rsp.seek_fail) begin
						state <= st_idle;
					end
				end
				st_xfer: begin
					if (sector_end) begin
						if (command_opcode == op_erase_unit && !next_abort) begin
							state <= st_erase;
						end else begin
							state <= st_idle;
						end
					end
				end
				st_erase: begin
					if (media_rsp.erase_done) begin
						state <= st_idle;
					end
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			command_opcode <= byte_zero;
		end else if (cmd_accept) begin
			command_opcode <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive_head_select <= head_reset;
		end else if (wr_fire && paddr == addr_head) begin
			drive_head_select <= pwdata[7:0];
		end
	end

	// Prepare arms only the command that directly follows it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			erase_armed <= 1'b0;
		end else if (cmd_accept) begin
			erase_armed <= (pwdata[7:0] == op_erase_prep);
		end
	end

	// Sector word counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			word_count <= byte_zero;
		end else if (cmd_accept) begin
			word_count <= byte_zero;
		end else if (state == st_xfer && data_write) begin
			word_count <= word_count + 8'h01;
		end
	end

	// Identifier taken from control word zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			id_master <= 1'b0;
		end else if (state == st_xfer && data_write &&
			word_count == byte_zero) begin
			id_master <= data_word[pw_id_bit];
		end
	end

	// Running password compare, cleared by each new command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pw_mismatch <= 1'b0;
		end else if (cmd_accept) begin
			pw_mismatch <= 1'b0;
		end else if (state == st_xfer && data_write && word_bad) begin
			pw_mismatch <= 1'b1;
		end
	end

	// Lock flag; master password is never written here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_enabled <= 1'b0;
		end else if (state == st_xfer && sector_end && !next_abort) begin
			lock_enabled <= (command_opcode == op_erase_unit) ? lock_enabled :
				1'b0;
		end else if (state == st_erase && media_rsp.erase_done) begin
			lock_enabled <= 1'b0;
		end else if (sec_write) begin
			lock_enabled <= pwdata[0];
		end
	end

	// Error and status error reporting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			error_flags <= byte_zero;
			status_err <= 1'b0;
		end else if (next_abort) begin
			error_flags <= byte_zero;
			error_flags[err_abort_bit] <= 1'b1;
			status_err <= 1'b1;
		end else if (state == st_seek && media_rsp.seek_fail) begin
			error_flags <= byte_zero;
			error_flags[err_track0_bit] <= 1'b1;
			status_err <= 1'b1;
		end else if (cmd_accept) begin
			error_flags <= byte_zero;
			status_err <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seek_complete <= 1'b0;
		end else if (state == st_seek) begin
			seek_complete <= media_rsp.seek_done;
		end else if (next_done) begin
			seek_complete <= 1'b1;
		end
	end

	// Seek request pulse for recalibrate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			media_req.seek_track0 <= 1'b0;
		end else begin
			media_req.seek_track0 <= cmd_accept &&
				(pwdata[7:4] == op_recal_hi);
		end
	end

	// Erase request pulse once the sector is accepted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			media_req.erase <= 1'b0;
		end else begin
			media_req.erase <= (state == st_xfer) && sector_end &&
				(command_opcode == op_erase_unit) && !next_abort;
		end
	end

	// Erase scope: whole native range, zero fill, no verify
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			media_req.erase_last_lba <= '0;
			media_req.erase_verify <= 1'b0;
			media_req.defect_update <= 1'b0;
		end else begin
			media_req.erase_last_lba <= native_max_lba;
			media_req.erase_verify <= 1'b0;
			media_req.defect_update <= 1'b0;
		end
	end

	// APB read data, one wait state
	always_comb begin
		next_prdata = word_zero;
		next_slverr = 1'b0;
		unique case (paddr)
			addr_data: next_slverr = !pwrite;
			addr_error: next_prdata[7:0] = error_flags;
			addr_head: next_prdata[7:0] = drive_head_select;
			addr_command: next_slverr = !pwrite;
			addr_status: next_prdata[7:0] = drive_status;
			addr_security: next_prdata[0] = lock_enabled;
			default: next_slverr = 1'b1;
		endcase
		if (pwrite && (paddr == addr_error || paddr == addr_status)) begin
			next_slverr = 1'b1;
		end
	end

	// Ready answers the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= bus_access;
		end
	end

	// Read data and error stand only with ready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= word_zero;
			pslverr <= 1'b0;
		end else begin
			prdata <= (bus_access && !pwrite) ? next_prdata : word_zero;
			pslverr <= bus_access && next_slverr;
		end
	end

endmodule

// [core/ata_sec_pkg.sv]
// Constants and types for the recalibrate and security erase command handler.
// Assumes a 32-bit APB register bus and same-clock media control logic.
package ata_sec_pkg;

	// Register byte addresses
	localparam logic [7:0] addr_data = 8'h00;
	localparam logic [7:0] addr_error = 8'h04;
	localparam logic [7:0] addr_head = 8'h08;
	localparam logic [7:0] addr_command = 8'h0C;
	localparam logic [7:0] addr_status = 8'h10;
	localparam logic [7:0] addr_security = 8'h14;

	// Opcodes
	localparam logic [3:0] op_recal_hi = 4'h1;
	localparam logic [7:0] op_disable_pw = 8'hF6;
	localparam logic [7:0] op_erase_prep = 8'hF3;
	localparam logic [7:0] op_erase_unit = 8'hF4;

	// Error bits
	localparam int err_abort_bit = 2;
	localparam int err_track0_bit = 1;

	// Status bits
	localparam int st_busy_bit = 7;
	localparam int st_ready_bit = 6;
	localparam int st_seek_done_bit = 4;
	localparam int st_drq_bit = 3;
	localparam int st_err_bit = 0;

	// Password sector layout, in 16-bit words
	localparam logic [7:0] pw_first_word = 8'h01;
	localparam logic [7:0] pw_last_word = 8'h10;
	localparam logic [7:0] sector_last_word = 8'hFF;
	localparam int pw_id_bit = 0;
	localparam int pw_bits = 256;

	// Reset values and LBA width
	localparam logic [7:0] head_reset = 8'hA0;
	localparam logic [7:0] byte_zero = 8'h00;
	localparam logic [31:0] word_zero = 32'h0000_0000;
	localparam int lba_bits = 28;

	typedef enum logic [3:0] {
		st_idle = 4'b0001,
		st_seek = 4'b0010,
		st_xfer = 4'b0100,
		st_erase = 4'b1000
	} cmd_state_type;

	// Requests to the servo and media writer
	typedef struct packed {
		logic seek_track0;
		logic erase;
		logic [lba_bits-1:0] erase_last_lba;
		logic erase_verify;
		logic defect_update;
	} media_req_type;

	// Answers from the servo and media writer
	typedef struct packed {
		logic seek_done;
		logic seek_fail;
		logic erase_done;
	} media_rsp_type;

endpackage

// [tb/ata_sec_cmd_monitor.sv]
// Assertions on the command handler ports.
// Assumes one pclk domain and presetn active low.
`timescale 1ns/100ps
module ata_sec_cmd_monitor
	import ata_sec_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	// Store and media
	input wire logic [lba_bits-1:0] native_max_lba,
	input wire logic lock_enabled,
	input wire media_req_type media_req,
	input wire media_rsp_type media_rsp
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [7:0] cur_op;
	logic [7:0] prev_op;
	logic [8:0] dcount;
	wire logic acc = psel && penable && pready && pwrite;
	// Last two commands written
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_op <= 8'h00;
			prev_op <= 8'h00;
		end else if (acc && paddr == addr_command) begin
			prev_op <= cur_op;
			cur_op <= pwdata[7:0];
		end
	end
	// Data words since the last command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dcount <= 9'h000;
		else if (acc && paddr == addr_command)
			dcount <= 9'h000;
		else if (acc && paddr == addr_data)
			dcount <= dcount + 9'h001;
	end
	sequence recal_wr;
		acc && paddr == addr_command && pwdata[7:4] == op_recal_hi;
	endsequence
	sequence sector_done;
		dcount == 9'h100;
	endsequence
	a_seek_start: assert property (
		recal_wr |-> ##[1:2] media_req.seek_track0)
		else $error("recalibrate gave no seek");
	a_seek_cause: assert property (
		$rose(media_req.seek_track0) |-> cur_op[7:4] == op_recal_hi)
		else $error("seek without recalibrate");
	a_erase_armed: assert property (
		media_req.erase |-> cur_op == op_erase_unit &&
		prev_op == op_erase_prep)
		else $error("erase without prepare");
	a_erase_sector: assert property (
		media_req.erase |-> sector_done)
		else $error("erase before full sector");
	a_erase_range: assert property (
		media_req.erase |-> media_req.erase_last_lba == native_max_lba)
		else $error("erase range wrong");
	a_no_verify: assert property (
		!(media_req.erase_verify || media_req.defect_update))
		else $error("verify or defect update requested");
	a_lock_clear: assert property (
		media_rsp.erase_done |-> ##[1:2] !lock_enabled)
		else $error("lock kept after erase");
	a_lock_fall: assert property (
		$fell(lock_enabled) |-> dcount == 9'h100 ||
		$past(media_rsp.erase_done) || $past(media_rsp.erase_done, 2))
		else $error("lock cleared without cause");
endmodule
bind ata_sec_cmd ata_sec_cmd_monitor ata_sec_cmd_monitor_i (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .pready, .native_max_lba,
	.lock_enabled, .media_req, .media_rsp);

// [tb/media_model.sv]
// Servo and media writer model.
// Assumes pclk; delay sets how slowly it answers.
`timescale 1ns/100ps
module media_model
	import ata_sec_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Behaviour
	input wire logic seek_fails,
	input wire logic [7:0] delay,
	// Media
	input wire media_req_type media_req,
	output media_rsp_type media_rsp
);
	logic [7:0] cnt;
	logic seeking;
	logic erasing;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 8'h00;
			seeking <= 1'b0;
			erasing <= 1'b0;
			media_rsp <= '0;
		end else begin
			media_rsp <= '0;
			if (media_req.seek_track0 || media_req.erase) begin
				seeking <= media_req.seek_track0;
				erasing <= media_req.erase;
				cnt <= delay;
			end else if (cnt != 8'h00)
				cnt <= cnt - 8'h01;
			else if (seeking || erasing) begin
				media_rsp.seek_done <= seeking && !seek_fails;
				media_rsp.seek_fail <= seeking && seek_fails;
				media_rsp.erase_done <= erasing;
				seeking <= 1'b0;
				erasing <= 1'b0;
			end
		end
	end
endmodule

// [tb/tb_ata_sec_cmd.sv]
// Testbench for the command handler.
// Assumes the media model and the bound checker.
`timescale 1ns/100ps
module tb_ata_sec_cmd import ata_sec_pkg::*;;
	typedef struct {string nm; logic [32:0] ex; logic [32:0] mk;} note_type;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fails = 0;
	logic [7:0] paddr = 8'h00, dly = 8'h01;
	logic [31:0] pwdata = 32'h0, prdata, rv;
	logic pready, pslverr, lock_enabled;
	logic [pw_bits-1:0] upw, mpw, pw;
	logic [lba_bits-1:0] lba;
	logic [5:0] ab = 6'b001110, lk = 6'b011111, pp = 6'b111000, idb = 6'b010010;
	media_req_type mreq;
	media_rsp_type mrsp;
	note_type notes[$], nt;
	int seed = 81, bad_count = 0, n_tests = 0, k, j, c;
	always #25 pclk = ~pclk;
	ata_sec_cmd ata_sec_cmd_i (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .user_password(upw),
		.master_password(mpw), .native_max_lba(lba), .lock_enabled,
		.media_req(mreq), .media_rsp(mrsp));
	media_model media_model_i (.pclk, .presetn, .seek_fails(fails),
		.delay(dly), .media_req(mreq), .media_rsp(mrsp));
	task summarize;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input string nm, input logic [32:0] got, ex, mk);
		n_tests++;
		if ((got & mk) !== (ex & mk)) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, ex & mk, got & mk);
		end
	endtask
	// Read results against the oldest note
	always @(posedge pclk) if (psel && penable && pready === 1'b1 && !pwrite) begin
		nt = notes.pop_front();
		chk(nt.nm, {pslverr, prdata}, nt.ex, nt.mk);
	end
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			bad_count++;
			summarize();
		end
		rv = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task rd(input logic [7:0] a, input logic [32:0] ex, mk, input string nm);
		notes.push_back('{nm, ex, mk});
		apb(1'b0, a, 32'h0);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task wait_idle;
		j = 0;
		do begin
			rd(addr_status, 33'h0, 33'h0, "poll");
			j++;
		end while (rv[st_busy_bit] !== 1'b0 && j < 100);
		if (rv[st_busy_bit] !== 1'b0) begin
			bad_count++;
			summarize();
		end
	endtask
	task send(input logic id, input logic [pw_bits-1:0] p);
		wr(addr_data, {31'h0, id});
		for (int n = 1; n < 256; n++)
			wr(addr_data, n <= 16 ? {16'h0, p[(n-1)*16 +: 16]} : $random(seed));
	endtask
	initial begin
		upw <= {8{$random(seed)}};
		mpw <= {8{$random(seed)}};
		lba <= 28'($random(seed));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(addr_error, 33'h0, 33'h1_FFFF_FFFF, "err_rst");
		rd(addr_head, 33'h0_0000_00A0, 33'h1_FFFF_FFFF, "head_rst");
		rd(8'h18, 33'h1_0000_0000, 33'h1_0000_0000, "unmapped");
		wr(addr_head, 32'h0000_00B0);
		rd(addr_head, 33'h0_0000_00B0, 33'h1_FFFF_FFFF, "head_rw");
		for (c = 0; c < 2; c++) begin
			fails <= c[0];
			wr(addr_command, {24'h0, op_recal_hi, 4'($random(seed))});
			wait_idle;
			rd(addr_status, c ? 33'h01 : 33'h10, c ? 33'h81 : 33'h91, "recal_st");
			rd(addr_error, c ? 33'h02 : 33'h0, 33'h1_FFFF_FFFF, "recal_err");
		end
		for (c = 0; c < 6; c++) begin
			pw = c == 4 ? mpw : c < 2 ? upw : {8{$random(seed)}};
			dly <= 8'($random(seed));
			wr(addr_security, {31'h0, lk[c]});
			if (pp[c]) begin
				wr(addr_command, {24'h0, op_erase_prep});
				rd(addr_status, 33'h0, 33'h89, "prep_st");
			end
			wr(addr_command,
				{24'h0, c < 2 ? op_disable_pw : op_erase_unit});
			if (c != 2) begin
				rd(addr_status, 33'h08, 33'h09, "drq_on");
				send(idb[c], pw);
				wait_idle;
			end
			rd(addr_status, {32'h0, ab[c]}, 33'h09, "end_st");
			rd(addr_error, ab[c] ? 33'h04 : 33'h0, 33'h1_FFFF_FFFF, "end_err");
			rd(addr_security, {32'h0, ab[c] & lk[c]}, 33'h1_FFFF_FFFF, "lock");
		end
		summarize();
	end
endmodule
